// ---- hdl/mfic_pkg.sv ----
package mfic_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h02;
    localparam logic [7:0] ADDR_FAULT_IRQ_ENABLE = 8'h03;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_IRQ_PULSE_MODE = 6;
    localparam int BIT_ACTIVE_NOT_STANDBY = 5;
    localparam int BIT_DIM_ACTIVE = 4;
    localparam int BIT_GAIN_DOWN_BLOCK = 3;
    localparam int BIT_INDEP_SINK_GROUP_ON = 2;
    localparam int BIT_BACKLIGHT_ON = 0;
    localparam int BIT_OVERLOAD = 4;
    localparam int BIT_OVERHEAT = 3;
    localparam int BIT_VOUT_OVER = 2;
    // ****************************************
    // writable masks and reset values
    // ****************************************
    localparam logic [7:0] MODE_CONTROL_MASK = 8'h7d;
    localparam logic [7:0] FAULT_MASK = 8'h1c;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int IRQ_GAP_NS = 50000;
    localparam int IRQ_GAP_CYCLES = (IRQ_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_CNT_W = 16;
endpackage

// ---- hdl/mfic_sync2.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous level inputs
module mfic_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // ****************************************
    // two flops, first only read by second
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// ---- hdl/mfic_gain_ctrl.sv ----
`timescale 1ns/1ps
// charge-pump gain stepper: 0=1x, 1=1.5x, 2=2x
module mfic_gain_ctrl (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable,
    input wire logic need_up,
    input wire logic may_down,
    input wire logic block_down,
    input wire logic all_sinks_off,
    output logic [1:0] gain
);
    logic [1:0] gain_r;
    logic [1:0] gain_nxt;

    // ****************************************
    // next gain
    // ****************************************
    always_comb
    begin
        gain_nxt = gain_r;
        if (!enable)
        begin
            // idle in standby
            gain_nxt = 2'h0;
        end
        else if (need_up && gain_r != 2'h2)
        begin
            gain_nxt = gain_r + 2'h1;
        end
        else if (may_down && gain_r != 2'h0)
        begin
            // step down unless blocked by a lit sink
            if (!block_down || all_sinks_off)
            begin
                gain_nxt = gain_r - 2'h1;
            end
        end
    end

    // ****************************************
    // gain register
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            gain_r <= 2'h0;
        else
            gain_r <= gain_nxt;
    end

    assign gain = gain_r;

    // ****************************************
    // checks
    // ****************************************
    a_gain_down_block: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($past(enable) && $past(block_down) && !$past(all_sinks_off)) |-> gain_r >= $past(gain_r))
        else $error("gain dropped while blocked");
endmodule

// ---- hdl/mfic_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - pulse mode: clear with pending drops irq 50us
// - level mode: irq stays asserted while pending
// - active bit 1 runs, 0 standby idle
// - dim bit set by timeout or host
// - dimming only while backlight enabled
// - gain-down block: no step down until sinks off
// - otherwise gain moves up and down freely
// - group bit gates independent sinks, direct overrides
// - backlight on only while active
// - faults set flags bits 4,3,2
// - write one clears flag, zero ignored
// - enabled set flag raises interrupt
// - disabled flag still held, no interrupt
// - reset and undervoltage restore defaults
// - reserved and unused bits read zero
module mfic_top #(
    parameter int SINKS = 7
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic uvlo,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic fault_overload,
    input wire logic fault_overheat,
    input wire logic fault_vout_over,
    input wire logic dim_timeout,
    input wire logic [SINKS-1:0] sink_is_indep,
    input wire logic [SINKS-1:0] per_sink_direct_en,
    input wire logic [SINKS-1:0] sink_lit,
    input wire logic pump_need_up,
    input wire logic pump_may_down,
    output logic irq_n,
    output logic active_not_standby,
    output logic backlight_on,
    output logic dim_active,
    output logic indep_sink_group_on,
    output logic [1:0] pump_gain
);
    // ****************************************
    // declarations
    // ****************************************
    localparam int GAP_CNT_W_L = mfic_pkg::GAP_CNT_W;
    localparam logic [GAP_CNT_W_L-1:0] GAP_LOAD = GAP_CNT_W_L'(mfic_pkg::IRQ_GAP_CYCLES);
    logic [2:0] fault_sync; // synchronised fault levels
    logic [2:0] fault_prev_r; // for rising edge detect
    logic [2:0] fault_prev_nxt;
    logic [7:0] mode_r; // mode control register
    logic [7:0] mode_nxt;
    logic [7:0] status_r; // sticky fault flags
    logic [7:0] status_nxt;
    logic [7:0] irq_en_r; // fault interrupt enables
    logic [7:0] irq_en_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic irq_n_r;
    logic irq_n_nxt;
    logic [GAP_CNT_W_L-1:0] gap_cnt_r; // gap timer for pulse mode
    logic [GAP_CNT_W_L-1:0] gap_cnt_nxt;
    logic [7:0] fault_set;
    logic [7:0] pending;
    logic clr_hit;
    logic bl_r;
    logic bl_nxt;
    logic dim_r;
    logic dim_nxt;
    logic grp_r;
    logic grp_nxt;

    // expand three fault levels to register positions
    function automatic logic [7:0] fault_vec(input logic [2:0] f);
        logic [7:0] v;
        v = 8'h00;
        v[mfic_pkg::BIT_OVERLOAD] = f[2];
        v[mfic_pkg::BIT_OVERHEAT] = f[1];
        v[mfic_pkg::BIT_VOUT_OVER] = f[0];
        return v;
    endfunction

    // ****************************************
    // fault input synchronisers
    // ****************************************
    mfic_sync2 #(
        .WIDTH(3)
    ) mfic_sync2_inst (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in({fault_overload, fault_overheat, fault_vout_over}),
        .sync_out(fault_sync)
    );

    // ****************************************
    // charge pump gain control
    // ****************************************
    mfic_gain_ctrl mfic_gain_ctrl_inst (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(mode_r[mfic_pkg::BIT_ACTIVE_NOT_STANDBY]),
        .need_up(pump_need_up),
        .may_down(pump_may_down),
        .block_down(mode_r[mfic_pkg::BIT_GAIN_DOWN_BLOCK]),
        .all_sinks_off(~|sink_lit),
        .gain(pump_gain)
    );

    // ****************************************
    // register file next state
    // ****************************************
    always_comb
    begin
        mode_nxt = mode_r;
        irq_en_nxt = irq_en_r;
        status_nxt = status_r;
        fault_prev_nxt = fault_sync;
        rdata_nxt = rdata_r;
        // flag set on fault rising edge
        fault_set = fault_vec(fault_sync & ~fault_prev_r);
        clr_hit = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                mfic_pkg::ADDR_MODE_CONTROL:
                begin
                    mode_nxt = reg_wdata & mfic_pkg::MODE_CONTROL_MASK;
                end
                mfic_pkg::ADDR_FAULT_STATUS:
                begin
                    status_nxt = status_r & ~(reg_wdata & mfic_pkg::FAULT_MASK);
                    clr_hit = |(reg_wdata & mfic_pkg::FAULT_MASK & status_r);
                end
                mfic_pkg::ADDR_FAULT_IRQ_ENABLE:
                begin
                    irq_en_nxt = reg_wdata & mfic_pkg::FAULT_MASK;
                end
                default:
                begin
                    // unmapped: ignored
                end
            endcase
        end
        if (dim_timeout && mode_r[mfic_pkg::BIT_BACKLIGHT_ON])
            mode_nxt[mfic_pkg::BIT_DIM_ACTIVE] = 1'b1;
        // set wins over clear, regardless of enable
        status_nxt = status_nxt | fault_set;
        // read returns zero in reserved and unmapped bits
        if (reg_rd)
        begin
            unique case (reg_addr)
                mfic_pkg::ADDR_MODE_CONTROL: rdata_nxt = mode_r;
                mfic_pkg::ADDR_FAULT_STATUS: rdata_nxt = status_r;
                mfic_pkg::ADDR_FAULT_IRQ_ENABLE: rdata_nxt = irq_en_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        if (uvlo)
        begin
            mode_nxt = mfic_pkg::REG_RESET;
            status_nxt = mfic_pkg::REG_RESET;
            irq_en_nxt = mfic_pkg::REG_RESET;
        end
    end

    // ****************************************
    // register file flops
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_r <= mfic_pkg::REG_RESET;
            status_r <= mfic_pkg::REG_RESET;
            irq_en_r <= mfic_pkg::REG_RESET;
            rdata_r <= 8'h00;
            fault_prev_r <= 3'h0;
        end
        else
        begin
            mode_r <= mode_nxt;
            status_r <= status_nxt;
            irq_en_r <= irq_en_nxt;
            rdata_r <= rdata_nxt;
            fault_prev_r <= fault_prev_nxt;
        end
    end

    // ****************************************
    // interrupt line next state
    // ****************************************
    always_comb
    begin
        pending = status_nxt & irq_en_nxt;
        gap_cnt_nxt = gap_cnt_r;
        irq_n_nxt = ~(|pending);
        if (gap_cnt_r != '0)
        begin
            gap_cnt_nxt = gap_cnt_r - GAP_CNT_W_L'(1);
            irq_n_nxt = 1'b1;
        end
        else if (clr_hit && (|pending) && mode_r[mfic_pkg::BIT_IRQ_PULSE_MODE])
        begin
            // clear with events left: start gap
            gap_cnt_nxt = GAP_LOAD - GAP_CNT_W_L'(1);
            irq_n_nxt = 1'b1;
        end
        // level mode: line follows pending directly
        if (uvlo)
            gap_cnt_nxt = '0;
    end

    // ****************************************
    // output state next values
    // ****************************************
    always_comb
    begin
        bl_nxt = mode_nxt[mfic_pkg::BIT_BACKLIGHT_ON] && mode_nxt[mfic_pkg::BIT_ACTIVE_NOT_STANDBY];
        dim_nxt = mode_nxt[mfic_pkg::BIT_DIM_ACTIVE] && bl_nxt;
        // standby idles group, direct enables freeze it
        if (!mode_nxt[mfic_pkg::BIT_ACTIVE_NOT_STANDBY])
            grp_nxt = 1'b0;
        else if (|per_sink_direct_en)
            grp_nxt = grp_r;
        else
            grp_nxt = mode_nxt[mfic_pkg::BIT_INDEP_SINK_GROUP_ON] && (|sink_is_indep);
    end

    // ****************************************
    // interrupt and output flops
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_n_r <= 1'b1;
            gap_cnt_r <= '0;
            bl_r <= 1'b0;
            dim_r <= 1'b0;
            grp_r <= 1'b0;
        end
        else
        begin
            irq_n_r <= irq_n_nxt;
            gap_cnt_r <= gap_cnt_nxt;
            bl_r <= bl_nxt;
            dim_r <= dim_nxt;
            grp_r <= grp_nxt;
        end
    end

    assign active_not_standby = mode_r[mfic_pkg::BIT_ACTIVE_NOT_STANDBY];
    assign backlight_on = bl_r;
    assign dim_active = dim_r;
    assign indep_sink_group_on = grp_r;
    assign irq_n = irq_n_r;
    assign reg_rdata = rdata_r;

    // ****************************************
    // checks
    // ****************************************
    a_pulse_gap_len: assert property (@(posedge clk_sys) disable iff (!resetn || uvlo)
        (gap_cnt_r == GAP_LOAD - GAP_CNT_W_L'(1)) |-> irq_n_r[*8])
        else $error("pulse gap too short");
    a_level_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!mode_r[mfic_pkg::BIT_IRQ_PULSE_MODE] && gap_cnt_r == '0 && |(status_nxt & irq_en_nxt))
        |=> !irq_n_r)
        else $error("irq dropped in level mode");
    a_standby_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !mode_r[mfic_pkg::BIT_ACTIVE_NOT_STANDBY] |-> (!bl_r && !grp_r))
        else $error("backlight on in standby");
    a_dim_needs_bl: assert property (@(posedge clk_sys) disable iff (!resetn)
        dim_r |-> bl_r)
        else $error("dim without backlight");
    a_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (fault_sync[2] && !fault_prev_r[2] && !uvlo) |=> status_r[mfic_pkg::BIT_OVERLOAD])
        else $error("overload flag not set");
    a_zero_write_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == mfic_pkg::ADDR_FAULT_STATUS && reg_wdata == 8'h00 && !uvlo)
        |=> (status_r & $past(status_r)) == $past(status_r))
        else $error("zero write cleared flag");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mode_r[7] == 1'b0) && (mode_r[1] == 1'b0) && ((status_r & ~mfic_pkg::FAULT_MASK) == 8'h00)
        && ((irq_en_r & ~mfic_pkg::FAULT_MASK) == 8'h00))
        else $error("reserved bit set");
    a_irq_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        ((status_r & irq_en_r) == 8'h00) |-> irq_n_r)
        else $error("irq without pending");
endmodule

// ---- bench/mfic_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host processor side of the register port
// ****************************************
module mfic_host_model (
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // bus idle at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write strobe; released lines show the inverse so stale values never match
    // one clears flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read strobe; data is taken by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// ---- bench/mfic_top_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// self-checking bench
// ****************************************
module mfic_top_tb;
    logic clk_sys, resetn, uvlo, reg_wr, reg_rd, irq_n, act, bl, dim, grp;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic f_ol, f_oh, f_vo, dim_to, nup, mdn;
    logic rd_seen = 1'b0; // read strobe seen at the last edge
    logic [6:0] indep, direct, lit;
    logic [1:0] gain;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    int seed = 32'h4b25e30f;
    mfic_top mfic_top_inst (.clk_sys(clk_sys), .resetn(resetn), .uvlo(uvlo), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fault_overload(f_ol), .fault_overheat(f_oh), .fault_vout_over(f_vo), .dim_timeout(dim_to),
        .sink_is_indep(indep), .per_sink_direct_en(direct), .sink_lit(lit), .pump_need_up(nup),
        .pump_may_down(mdn), .irq_n(irq_n), .active_not_standby(act), .backlight_on(bl),
        .dim_active(dim), .indep_sink_group_on(grp), .pump_gain(gain));
    mfic_host_model mfic_host_model_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // note the expected data, then read
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        mfic_host_model_inst.rd(a);
    endtask
    // monitor: read data lands the edge after the strobe
    always @(posedge clk_sys)
        rd_seen <= reg_rd;
    always @(negedge clk_sys)
    begin
        if (rd_seen === 1'b1)
            check(reg_rdata, exp_q.pop_front());
    end
    // fault inputs high for three cycles, then settle
    task automatic fault(input logic [2:0] f);
        @(posedge clk_sys);
        {f_ol, f_oh, f_vo} <= f;
        repeat (3) @(posedge clk_sys);
        {f_ol, f_oh, f_vo} <= 3'b000;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // one-cycle pulse on a same-clock input
    task automatic step(input logic u, input logic d);
        @(posedge clk_sys);
        nup <= u;
        mdn <= d;
        @(posedge clk_sys);
        nup <= 1'b0;
        mdn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wait_neg();
        repeat (2) @(negedge clk_sys);
    endtask
    // verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        n_mismatch++;
        close_out();
    end
    // main sequence
    initial
    begin
        {resetn, uvlo, f_ol, f_oh, f_vo, dim_to, nup, mdn} = 8'h00;
        indep = $random(seed) | 7'h01;
        lit = $random(seed) | 7'h01;
        direct = 7'h00;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // defaults and unmapped places
        check(irq_n, 1'b1);
        rdx(8'h00, 8'h00);
        rdx(mfic_pkg::ADDR_MODE_CONTROL, mfic_pkg::REG_RESET);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, mfic_pkg::REG_RESET);
        rdx(mfic_pkg::ADDR_FAULT_IRQ_ENABLE, mfic_pkg::REG_RESET);
        rdx(8'h04, 8'h00);
        $display("test defaults done");
        // mode bits and reserved positions
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'hff);
        rdx(mfic_pkg::ADDR_MODE_CONTROL, mfic_pkg::MODE_CONTROL_MASK);
        wait_neg();
        check({act, bl, dim, grp}, 4'hf);
        // a direct sink enable freezes the group output
        @(posedge clk_sys);
        direct <= 7'h02;
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h21);
        wait_neg();
        check(grp, 1'b1);
        @(posedge clk_sys);
        direct <= 7'h00;
        wait_neg();
        check(grp, 1'b0);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h34);
        indep <= 7'h00;
        wait_neg();
        check({act, bl, dim, grp}, 4'h8);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h05);
        indep <= $random(seed) | 7'h01;
        wait_neg();
        check({act, bl, grp}, 3'h0);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h21);
        @(posedge clk_sys);
        dim_to <= 1'b1;
        @(posedge clk_sys);
        dim_to <= 1'b0;
        rdx(mfic_pkg::ADDR_MODE_CONTROL, 8'h31);
        wait_neg();
        check(dim, 1'b1);
        $display("test mode done");
        // flag held without interrupt, zero writes ignored
        fault(3'b100);
        check(irq_n, 1'b1);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_STATUS, 8'h00);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h10);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h10);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_IRQ_ENABLE, 8'hff);
        rdx(mfic_pkg::ADDR_FAULT_IRQ_ENABLE, mfic_pkg::FAULT_MASK);
        wait_neg();
        check(irq_n, 1'b0);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_STATUS, 8'hff);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h00);
        check(irq_n, 1'b1);
        $display("test flags done");
        // level mode: clearing one of two pending keeps the line low
        fault(3'b011);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h0c);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_STATUS, 8'h08);
        wait_neg();
        check(irq_n, 1'b0);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h04);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_STATUS, 8'h04);
        wait_neg();
        check(irq_n, 1'b1);
        $display("test level done");
        // pulse mode: the line rises for the gap, then falls again
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h60);
        fault(3'b110);
        check(irq_n, 1'b0);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_FAULT_STATUS, 8'h10);
        @(negedge clk_sys);
        check(irq_n, 1'b1);
        n = 0;
        while (irq_n === 1'b1 && n < 7000)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(n == mfic_pkg::IRQ_GAP_CYCLES, 1'b1);
        check(irq_n, 1'b0);
        $display("test pulse done");
        // gain moves both ways, then is held up while sinks are lit
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h20);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        check(gain, 2'h2);
        step(1'b0, 1'b1);
        check(gain, 2'h1);
        mfic_host_model_inst.wr(mfic_pkg::ADDR_MODE_CONTROL, 8'h28);
        step(1'b0, 1'b1);
        check(gain, 2'h1);
        @(posedge clk_sys);
        lit <= 7'h00;
        step(1'b0, 1'b1);
        check(gain, 2'h0);
        $display("test gain done");
        // undervoltage restores defaults
        @(posedge clk_sys);
        uvlo <= 1'b1;
        @(posedge clk_sys);
        uvlo <= 1'b0;
        rdx(mfic_pkg::ADDR_MODE_CONTROL, 8'h00);
        rdx(mfic_pkg::ADDR_FAULT_STATUS, 8'h00);
        rdx(mfic_pkg::ADDR_FAULT_IRQ_ENABLE, 8'h00);
        wait_neg();
        check(irq_n, 1'b1);
        $display("test uvlo done");
        close_out();
    end
endmodule
